// *** logic/block_cipher_security_engine.sv ***
`timescale 1ns/1ns
module block_cipher_security_engine (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic spi_csn_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_en,
  input wire logic sleep_state,
  input wire logic transceiver_off_state,
  input wire logic [2:0] master_clock_output_select,
  output logic engine_running,
  output logic cipher_done,
  output logic cipher_error_flag
);
  import cipher_pkg::*;

  link_state_type link, next_link;
  sys_state_type sys, next_sys;
  frame_byte_type rx;
  run_request_type core_request;
  run_result_type core_result;
  logic link_clear;
  logic frame_clear;
  logic tx_load;
  logic [7:0] tx_byte;
  logic done_seen;
  logic start_seen;
  logic core_start;
  logic core_finished;
  logic engine_hold;

  function automatic logic in_page(input logic [7:0] a);
    return (a >= PAGE_FIRST) && (a <= PAGE_LAST);
  endfunction

  function automatic logic is_control(input logic [7:0] a);
    return (a == CONTROL_ADDR) || (a == CONTROL_COPY_ADDR);
  endfunction

  function automatic logic [2:0] mode_of(input logic [7:0] c);
    return c[MODE_LSB +: 3];
  endfunction

  // byte 0x84 is the most significant byte of a page
  function automatic logic [7:0] get_byte(input logic [127:0] p, input logic [7:0] a);
    logic [3:0] i;
    i = 4'(a - PAGE_FIRST);
    return p[127 - 8 * i -: 8];
  endfunction

  function automatic logic [127:0] put_byte(input logic [127:0] p, input logic [7:0] a,
                                            input logic [7:0] b);
    logic [127:0] o;
    logic [3:0] i;
    o = p;
    i = 4'(a - PAGE_FIRST);
    o[127 - 8 * i -: 8] = b;
    return o;
  endfunction

  // what a read of address a returns; unmapped bytes read as zero
  function automatic logic [7:0] read_byte(input link_state_type s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == STATUS_ADDR) begin
      r[ERROR_BIT] = s.error;
      r[DONE_BIT] = s.done;
    end else if (is_control(a)) begin
      r = s.control;
    end else if (in_page(a) && mode_of(s.control) == MODE_KEY_LOAD) begin
      r = get_byte(s.round_key, a);
    end else if (in_page(a)) begin
      r = get_byte(s.data_page, a);
    end
    return r;
  endfunction

  // sleep clears the link side at once, even with the serial clock stopped
  assign link_clear = rst | sleep_state;
  assign frame_clear = link_clear | spi_csn_n;

  spi_frame u_frame (
    .spi_clk(spi_clk),
    .frame_clear(frame_clear),
    .spi_mosi(spi_mosi),
    .load(tx_load),
    .load_byte(tx_byte),
    .byte_event(rx),
    .spi_miso(spi_miso)
  );

  // the result words only change after a start, which waits for this edge,
  // so they are stable when the synchronised toggle is seen
  assign done_seen = link.done_sync[2] ^ link.done_sync[1];

  // link side: byte decode of the sram window on the serial clock
  always_comb begin
    next_link = link;
    tx_load = 1'b0;
    tx_byte = 8'h00;
    next_link.done_sync = {link.done_sync[1:0], sys.done_toggle};
    if (done_seen) begin
      next_link.data_page = sys.result.block;
      next_link.round_key = sys.result.last_key;
      next_link.busy = 1'b0;
      next_link.done = 1'b1;
    end
    if (rx.valid) begin
      case (rx.phase)
        phase_cmd: begin
          // a data page read that stopped short is caught at the next frame
          if (link.is_read && link.read_count != 5'h00 && link.read_count != BLOCK_BYTES) begin
            next_link.error = 1'b1;
          end
          next_link.is_write = (rx.data[7:6] == SPI_WRITE_CMD);
          next_link.is_read = (rx.data[7:6] == SPI_READ_CMD);
          next_link.read_count = 5'h00;
        end
        phase_addr: begin
          next_link.addr = rx.data;
          if (link.is_read) begin
            tx_load = 1'b1;
            tx_byte = read_byte(link, rx.data);
          end
        end
        phase_data: begin
          if (link.is_write) begin
            // old content goes out during the next byte
            tx_load = 1'b1;
            tx_byte = read_byte(link, link.addr);
            if (is_control(link.addr) && link.busy) begin
              next_link.error = 1'b1;
            end else if (is_control(link.addr)) begin
              next_link.control = rx.data;
              next_link.control[REQUEST_BIT] = 1'b0;
              if (rx.data[REQUEST_BIT] && mode_of(rx.data) != MODE_KEY_LOAD) begin
                next_link.request.mode = mode_of(rx.data);
                next_link.request.decrypt = rx.data[DIR_BIT];
                next_link.request.key = link.init_key;
                next_link.request.block = link.data_page;
                next_link.start_toggle = ~link.start_toggle;
                next_link.busy = 1'b1;
                next_link.done = 1'b0;
              end
            end else if (in_page(link.addr) && mode_of(link.control) == MODE_KEY_LOAD) begin
              next_link.init_key = put_byte(link.init_key, link.addr, rx.data);
            end else if (in_page(link.addr)) begin
              next_link.data_page = put_byte(link.data_page, link.addr, rx.data);
            end
          end else if (link.is_read) begin
            tx_load = 1'b1;
            tx_byte = read_byte(link, link.addr + 8'h01);
            if (is_control(link.addr) && link.busy) begin
              next_link.error = 1'b1;
            end
            if (in_page(link.addr) && mode_of(link.control) != MODE_KEY_LOAD
                && link.read_count != BLOCK_BYTES) begin
              next_link.read_count = link.read_count + 5'h01;
            end
          end
          // bursts walk upward through the window
          next_link.addr = link.addr + 8'h01;
        end
        default: begin
          next_link.addr = link.addr;
        end
      endcase
    end
  end

  // link registers; cleared by reset or sleep
  always_ff @(posedge spi_clk or posedge link_clear) begin
    if (link_clear) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // master clock output off in the off state stops the engine
  assign engine_hold = transceiver_off_state && (master_clock_output_select == 3'h0);

  assign start_seen = sys.start_sync[2] ^ sys.start_sync[1];

  // chained mode folds the previous result into the new block
  always_comb begin
    core_request = link.request;
    if (link.request.mode == MODE_CBC) begin
      core_request.block = link.request.block ^ sys.prev_block;
    end
  end

  // engine side: runs on the system clock apart from the radio
  always_comb begin
    next_sys = sys;
    core_start = 1'b0;
    next_sys.start_sync = {sys.start_sync[1:0], link.start_toggle};
    case (sys.phase)
      eng_idle: begin
        if (start_seen) begin
          core_start = 1'b1;
          next_sys.run_count = 8'h00;
          next_sys.phase = eng_run;
        end
      end
      eng_run: begin
        // the flag waits for the full processing time even if rounds end early
        if (!engine_hold && sys.run_count != RUN_LAST) begin
          next_sys.run_count = sys.run_count + 8'h01;
        end
        // a paused engine never completes, even on its last counted cycle
        if (core_finished && !engine_hold && sys.run_count == RUN_LAST) begin
          next_sys.result = core_result;
          next_sys.prev_block = core_result.block;
          next_sys.done_toggle = ~sys.done_toggle;
          next_sys.phase = eng_idle;
        end
      end
      default: begin
        next_sys.phase = eng_idle;
      end
    endcase
    if (sleep_state) begin
      next_sys = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  cipher_round_core u_core (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(sleep_state),
    .hold(engine_hold),
    .start(core_start),
    .request(core_request),
    .finished(core_finished),
    .result(core_result)
  );

  // miso is driven only inside an open frame and never during sleep
  assign spi_miso_en = ~spi_csn_n & ~link_clear;
  assign engine_running = (sys.phase == eng_run);
  assign cipher_done = link.done;
  assign cipher_error_flag = link.error;

endmodule // block_cipher_security_engine

// *** logic/cipher_pkg.sv ***
package cipher_pkg;

  // byte window of the engine, reached only through sram accesses
  localparam logic [7:0] STATUS_ADDR = 8'h82;
  localparam logic [7:0] CONTROL_ADDR = 8'h83;
  localparam logic [7:0] PAGE_FIRST = 8'h84;
  localparam logic [7:0] PAGE_LAST = 8'h93;
  localparam logic [7:0] CONTROL_COPY_ADDR = 8'h94;

  // top two bits of the first byte of a serial frame
  localparam logic [1:0] SPI_READ_CMD = 2'h0;
  localparam logic [1:0] SPI_WRITE_CMD = 2'h1;

  // mode field values
  localparam logic [2:0] MODE_ECB = 3'h0;
  localparam logic [2:0] MODE_KEY_LOAD = 3'h1;
  localparam logic [2:0] MODE_CBC = 3'h2;

  // control and status byte layout
  localparam int REQUEST_BIT = 7;
  localparam int MODE_LSB = 4;
  localparam int DIR_BIT = 3;
  localparam int ERROR_BIT = 7;
  localparam int DONE_BIT = 0;

  // processing time before the completion flag rises
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int RUN_TIME_NS = 24000;
  localparam int RUN_CYCLES = (RUN_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [7:0] RUN_LAST = 8'(RUN_CYCLES - 1);

  localparam logic [4:0] BLOCK_BYTES = 5'h10;
  localparam logic [3:0] LAST_ROUND = 4'ha;

  typedef enum logic [1:0] {phase_cmd, phase_addr, phase_data} frame_phase_type;
  typedef enum logic {eng_idle, eng_run} engine_phase_type;

  typedef struct packed {
    logic valid;
    frame_phase_type phase;
    logic [7:0] data;
  } frame_byte_type;

  typedef struct packed {
    logic [2:0] mode;
    logic decrypt;
    logic [127:0] key;
    logic [127:0] block;
  } run_request_type;

  typedef struct packed {
    logic [127:0] block;
    logic [127:0] last_key;
  } run_result_type;

  typedef struct packed {
    frame_phase_type phase;
    logic [2:0] bit_count;
    logic [6:0] shift;
    logic [7:0] tx;
  } frame_state_type;

  typedef struct packed {
    logic [2:0] done_sync;
    logic is_write;
    logic is_read;
    logic [7:0] addr;
    logic [7:0] control;
    logic [127:0] init_key;
    logic [127:0] round_key;
    logic [127:0] data_page;
    run_request_type request;
    logic start_toggle;
    logic busy;
    logic done;
    logic error;
    logic [4:0] read_count;
  } link_state_type;

  typedef struct packed {
    logic [2:0] start_sync;
    engine_phase_type phase;
    logic [7:0] run_count;
    logic [127:0] prev_block;
    run_result_type result;
    logic done_toggle;
  } sys_state_type;

  typedef struct packed {
    logic [127:0] block;
    logic [127:0] key;
    logic [3:0] round;
    logic decrypt;
    logic running;
  } core_state_type;

endpackage

// *** logic/cipher_round_core.sv ***
`timescale 1ns/1ns
module cipher_round_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic hold,
  input wire logic start,
  input cipher_pkg::run_request_type request,
  output logic finished,
  output cipher_pkg::run_result_type result
);
  import cipher_pkg::*;

  core_state_type st, next_st;
  logic [7:0] rc;
  logic [127:0] t, nk;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction

  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // field inverse as a to the 254th; avoids two 256-entry tables
  function automatic logic [7:0] inv8(input logic [7:0] a);
    logic [7:0] r;
    r = a;
    for (int i = 0; i < 6; i++) r = gm(gm(r, r), a);
    return gm(r, r);
  endfunction

  function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
    logic [15:0] d;
    d = {a, a} << n;
    return d[15:8];
  endfunction

  function automatic logic [7:0] sub(input logic [7:0] a, input logic inv);
    logic [7:0] x;
    x = inv8(a);
    if (inv) return inv8(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ 8'h05);
    return x ^ rotl(x, 1) ^ rotl(x, 2) ^ rotl(x, 3) ^ rotl(x, 4) ^ 8'h63;
  endfunction

  // substitution and row shift in one pass; byte i sits at row i%4, column i/4
  function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (c - r + 4) % 4 : (c + r) % 4;
        o[127 - 8 * (4 * c + r) -: 8] = sub(s[127 - 8 * (4 * src + r) -: 8], inv);
      end
    end
    return o;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [31:0] cf;
    o = '0;
    cf = inv ? 32'h0e0b0d09 : 32'h02030101;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        for (int j = 0; j < 4; j++) begin
          o[127 - 8 * (4 * c + r) -: 8] = o[127 - 8 * (4 * c + r) -: 8]
            ^ gm(s[127 - 8 * (4 * c + j) -: 8], cf[31 - 8 * ((j - r + 4) % 4) -: 8]);
        end
      end
    end
    return o;
  endfunction

  function automatic logic [31:0] subrot(input logic [31:0] w);
    return {sub(w[23:16], 1'b0), sub(w[15:8], 1'b0), sub(w[7:0], 1'b0), sub(w[31:24], 1'b0)};
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] r);
    logic [7:0] c;
    c = 8'h01;
    for (int i = 1; i < 10; i++) if (i < r) c = xt(c);
    return c;
  endfunction

  function automatic logic [127:0] expand(input logic [127:0] k, input logic [7:0] c);
    logic [31:0] n0, n1, n2;
    n0 = k[127:96] ^ subrot(k[31:0]) ^ {c, 24'h000000};
    n1 = k[95:64] ^ n0;
    n2 = k[63:32] ^ n1;
    return {n0, n1, n2, k[31:0] ^ n2};
  endfunction

  // walks the schedule backwards so decryption starts from the last round key
  function automatic logic [127:0] unexpand(input logic [127:0] n, input logic [7:0] c);
    logic [31:0] w3;
    w3 = n[31:0] ^ n[63:32];
    return {n[127:96] ^ subrot(w3) ^ {c, 24'h000000}, n[95:64] ^ n[127:96],
      n[63:32] ^ n[95:64], w3};
  endfunction

  // one round per clock; hold freezes the run while the engine clock is off
  always_comb begin
    next_st = st;
    rc = rcon(st.decrypt ? 4'(LAST_ROUND + 4'h1 - st.round) : st.round);
    nk = st.decrypt ? unexpand(st.key, rc) : expand(st.key, rc);
    t = sub_shift(st.block, st.decrypt);
    if (start) begin
      next_st.block = request.block ^ request.key;
      next_st.key = request.key;
      next_st.round = 4'h1;
      next_st.decrypt = request.decrypt;
      next_st.running = 1'b1;
    end else if (st.running && !hold) begin
      if (st.decrypt) begin
        t = t ^ nk;
        if (st.round != LAST_ROUND) t = mix(t, 1'b1);
      end else begin
        if (st.round != LAST_ROUND) t = mix(t, 1'b0);
        t = t ^ nk;
      end
      next_st.block = t;
      next_st.key = nk;
      next_st.round = st.round + 4'h1;
      next_st.running = (st.round != LAST_ROUND);
    end
    if (clear) next_st = '0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign finished = !st.running;
  assign result.block = st.block;
  assign result.last_key = st.key;

endmodule // cipher_round_core

// *** logic/spi_frame.sv ***
`timescale 1ns/1ns
module spi_frame (
  input wire logic spi_clk,
  input wire logic frame_clear,
  input wire logic spi_mosi,
  input wire logic load,
  input wire logic [7:0] load_byte,
  output cipher_pkg::frame_byte_type byte_event,
  output logic spi_miso
);
  import cipher_pkg::*;

  frame_state_type st, next_st;

  // the byte is handed over on its eighth edge; the last byte of a frame
  // has no later edge, so it cannot wait for a register stage
  always_comb begin
    next_st = st;
    byte_event.valid = (st.bit_count == 3'h7);
    byte_event.phase = st.phase;
    byte_event.data = {st.shift, spi_mosi};
    next_st.shift = {st.shift[5:0], spi_mosi};
    next_st.bit_count = st.bit_count + 3'h1;
    if (byte_event.valid && st.phase == phase_cmd) begin
      next_st.phase = phase_addr;
    end else if (byte_event.valid) begin
      next_st.phase = phase_data;
    end
    next_st.tx = load ? load_byte : {st.tx[6:0], 1'b0};
  end

  // chip select high clears the frame; the clock may be stopped then
  always_ff @(posedge spi_clk or posedge frame_clear) begin
    if (frame_clear) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign spi_miso = st.tx[7];

endmodule // spi_frame

// *** verif/cipher_engine_properties.sv ***
`timescale 1ns/1ns
module cipher_engine_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic spi_csn_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_en,
  input wire logic sleep_state,
  input wire logic transceiver_off_state,
  input wire logic [2:0] master_clock_output_select,
  input wire logic engine_running,
  input wire logic cipher_done,
  input wire logic cipher_error_flag
);
  import cipher_pkg::*;
  logic [8:0] run_cnt;
  // counts unpaused run cycles; paused cycles do not add to the processing time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_cnt <= 9'h000;
    end else if (!engine_running) begin
      run_cnt <= 9'h000;
    end else if (!(transceiver_off_state && master_clock_output_select == 3'h0)) begin
      run_cnt <= run_cnt + 9'h001;
    end
  end
  a_miso_sleep_off: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_state |-> !spi_miso_en) else $error("miso driven during sleep");
  a_miso_frame_only: assert property (@(posedge sys_clk) disable iff (rst)
    spi_csn_n |-> !spi_miso_en) else $error("miso driven outside a frame");
  a_run_length: assert property (@(posedge sys_clk) disable iff (rst || sleep_state)
    $fell(engine_running) |-> int'(run_cnt) >= RUN_CYCLES - 1 && int'(run_cnt) <= RUN_CYCLES + 2)
    else $error("run length differs from processing time");
  a_paused_hold: assert property (@(posedge sys_clk) disable iff (rst || sleep_state)
    engine_running && transceiver_off_state && master_clock_output_select == 3'h0
    |=> engine_running) else $error("run ended while clock output was off");
  a_done_clear_run: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(engine_running) |-> !cipher_done) else $error("done flag set as a run starts");
  a_done_after_run: assert property (@(posedge spi_clk) disable iff (rst)
    $rose(cipher_done) |-> !engine_running) else $error("done flag rose while running");
  a_sleep_clears: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_state |-> !cipher_done && !cipher_error_flag ##1 !engine_running)
    else $error("sleep did not clear the engine");
  a_error_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    cipher_error_flag |=> cipher_error_flag || sleep_state) else $error("error flag dropped");
endmodule // cipher_engine_properties

bind block_cipher_security_engine cipher_engine_properties u_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .spi_clk(spi_clk),
  .spi_csn_n(spi_csn_n),
  .spi_mosi(spi_mosi),
  .spi_miso(spi_miso),
  .spi_miso_en(spi_miso_en),
  .sleep_state(sleep_state),
  .transceiver_off_state(transceiver_off_state),
  .master_clock_output_select(master_clock_output_select),
  .engine_running(engine_running),
  .cipher_done(cipher_done),
  .cipher_error_flag(cipher_error_flag)
);

// *** verif/host_spi_model.sv ***
`timescale 1ns/1ns
module host_spi_model (
  output logic spi_clk,
  output logic spi_csn_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] got;
  event got_ev;
  // link clock stands still between frames
  initial begin
    spi_clk = 1'b0;
    spi_csn_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one byte, msb first, 30 ns bit time; miso is taken in the low phase just
  // before each rising edge, since the device moves it right after that edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      #15 rx[i] = spi_miso;
      spi_clk = 1'b1;
      #15 spi_clk = 1'b0;
    end
  endtask
  // command, address, then data bytes at rising addresses; each data reply is reported
  task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] d[$]);
    logic [7:0] rx;
    spi_csn_n = 1'b0;
    #15;
    xfer(cmd, rx);
    xfer(addr, rx);
    foreach (d[k]) begin
      xfer(d[k], rx);
      got = rx;
      -> got_ev;
    end
    #15 spi_csn_n = 1'b1;
    spi_mosi = ~spi_mosi;  // released line must not keep its last value
    #30;
  endtask
endmodule // host_spi_model

// *** verif/test_block_cipher_security_engine.sv ***
`timescale 1ns/1ns
module test_block_cipher_security_engine;
  import cipher_pkg::*;
  logic sys_clk, rst, spi_clk, spi_csn_n, spi_mosi, spi_miso, spi_miso_en;
  logic sleep_state, transceiver_off_state, engine_running, cipher_done, cipher_error_flag;
  logic [2:0] master_clock_output_select;
  logic [8:0] exp_q[$];  // bit 8 set where the reply byte is compared
  logic [8:0] e;
  logic [7:0] d[$];
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;
  // reference vectors of the block cipher standard
  localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] PLAIN = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] CIPHER = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] LAST_KEY = 128'h13111d7fe3944a17f307a78b4d2b30c5;

  block_cipher_security_engine u_dut (.sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk),
    .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_en(spi_miso_en),
    .sleep_state(sleep_state), .transceiver_off_state(transceiver_off_state),
    .master_clock_output_select(master_clock_output_select), .engine_running(engine_running),
    .cipher_done(cipher_done), .cipher_error_flag(cipher_error_flag));
  host_spi_model u_host (.spi_clk(spi_clk), .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected miso byte: expected %h, seen %h", exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask

  // replies are matched against the oldest note; an unplanned reply is a mismatch
  always @(u_host.got_ev) begin
    if (exp_q.size() == 0) check_flag("reply note", 1'b1, 1'b0);
    else begin
      e = exp_q.pop_front();
      if (e[8]) check_byte(e[7:0], u_host.got);
    end
  end

  // a hang ends the run through the same report
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      $display("unexpected cycle count: expected below 10000, seen %0d", cycles);
      conclude();
    end
  end

  // page bytes go out from 0x84 first, that is bits 127:120 first
  task automatic put_block(input logic [127:0] b);
    for (int k = 15; k >= 0; k--) d.push_back(b[8*k +: 8]);
  endtask
  task automatic expect_block(input logic [127:0] b);
    for (int k = 15; k >= 0; k--) exp_q.push_back({1'b1, b[8*k +: 8]});
  endtask
  task automatic wr(input logic [7:0] addr);
    repeat (d.size()) exp_q.push_back(9'h000);
    u_host.frame({SPI_WRITE_CMD, 6'h00}, addr, d);
    d = {};
  endtask
  task automatic rd(input logic [7:0] addr, input int n);
    d = {};
    repeat (n) d.push_back(8'h00);
    u_host.frame({SPI_READ_CMD, 6'h00}, addr, d);
    d = {};
  endtask
  // bounded wait for a run to start and finish
  task automatic wait_run();
    int n;
    n = 0;
    while (engine_running !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check_flag("engine_running", 1'b1, engine_running);
    while (engine_running !== 1'b0 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    check_flag("engine_running", 1'b0, engine_running);
  endtask

  initial begin
    rst = 1'b1;
    sleep_state = 1'b0;
    transceiver_off_state = 1'b0;
    master_clock_output_select = 3'h0;
    seed = $urandom(83514);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    transceiver_off_state <= 1'($urandom_range(1, 0));
    master_clock_output_select <= 3'($urandom_range(7, 1));
    @(posedge sys_clk);
    check_flag("cipher_done", 1'b0, cipher_done);
    // key load, then an ecb encryption with start appended at the copy byte
    d = {8'h10};
    put_block(KEY);
    wr(CONTROL_ADDR);
    d = {8'h00};
    put_block(PLAIN);
    d.push_back(8'h80);
    wr(CONTROL_ADDR);
    wait_run();
    exp_q.push_back({1'b1, 8'h01});
    rd(STATUS_ADDR, 1);
    // fast write of a new run returns the old result one byte late
    exp_q.push_back(9'h000);
    expect_block(CIPHER);
    put_block(PLAIN);
    d.push_back(8'h80);
    u_host.frame({SPI_WRITE_CMD, 6'h00}, PAGE_FIRST, d);
    d = {};
    wait_run();
    expect_block(CIPHER);
    rd(PAGE_FIRST, 16);
    // chaining: plain xor cipher chained onto cipher gives cipher again
    d = {8'h20};
    put_block(PLAIN ^ CIPHER);
    d.push_back(8'ha0);
    wr(CONTROL_ADDR);
    wait_run();
    expect_block(CIPHER);
    rd(PAGE_FIRST, 16);
    d = {8'h10};
    wr(CONTROL_ADDR);
    expect_block(LAST_KEY);
    rd(PAGE_FIRST, 16);
    // the last round key decrypts the cipher text
    d = {8'h10};
    put_block(LAST_KEY);
    wr(CONTROL_ADDR);
    d = {8'h08};
    put_block(CIPHER);
    d.push_back(8'h88);
    wr(CONTROL_ADDR);
    wait_run();
    expect_block(PLAIN);
    rd(PAGE_FIRST, 16);
    d = {8'($urandom())};
    wr(8'ha0);
    exp_q.push_back({1'b1, 8'h00});
    rd(8'ha0, 1);
    // control access during a run, with the clock output paused for a while
    d = {8'h80};
    wr(CONTROL_ADDR);
    @(posedge sys_clk);
    transceiver_off_state <= 1'b1;
    master_clock_output_select <= 3'h0;
    repeat (50) @(posedge sys_clk);
    transceiver_off_state <= 1'b0;  // off state left: a disabled clock output no longer pauses
    d = {8'h00};
    wr(CONTROL_ADDR);
    wait_run();
    exp_q.push_back({1'b1, 8'h81});
    rd(STATUS_ADDR, 1);
    // a burst during sleep is ignored and sleep clears everything
    @(posedge sys_clk);
    sleep_state <= 1'b1;
    d = {8'h00};
    put_block(PLAIN);
    wr(CONTROL_ADDR);
    @(posedge sys_clk);
    check_flag("cipher_error_flag", 1'b0, cipher_error_flag);
    sleep_state <= 1'b0;
    repeat (3) @(posedge sys_clk);
    expect_block(128'h0);
    rd(PAGE_FIRST, 16);
    // the key page was cleared as well
    d = {8'h10};
    wr(CONTROL_ADDR);
    expect_block(128'h0);
    rd(PAGE_FIRST, 16);
    conclude();
  end
endmodule // test_block_cipher_security_engine
